// [src/adcsc_consts.vh]
`ifndef ADCSC_CONSTS_VH
`define ADCSC_CONSTS_VH

// ----------------------------------------
// timing
// ----------------------------------------
`define ADCSC_CLK_PERIOD_NS 10
`define ADCSC_RC_TAD_NS 4000
`define ADCSC_RC_TAD_CYCLES (`ADCSC_RC_TAD_NS / `ADCSC_CLK_PERIOD_NS)
`define ADCSC_OSC_DIV 5
`define ADCSC_DIV_2 2
`define ADCSC_DIV_8 8
`define ADCSC_DIV_32 32
`define ADCSC_TAD_CNT_W 16
`define ADCSC_GAP_TADS 4'h2
`define ADCSC_STEP_TRIAL 4'h1
`define ADCSC_STEP_LOAD 4'hC

// ----------------------------------------
// register indices (byte address = index * 4)
// ----------------------------------------
`define ADCSC_IDX_W 10
`define ADCSC_IDX_RESH 10'h01E
`define ADCSC_IDX_CTRL 10'h01F
`define ADCSC_IDX_IRQ 10'h020
`define ADCSC_IDX_RESL 10'h09E
`define ADCSC_IDX_CFG 10'h09F

// ----------------------------------------
// adc_control fields
// ----------------------------------------
`define ADCSC_CTRL_CLK_HI 7
`define ADCSC_CTRL_CLK_LO 6
`define ADCSC_CTRL_CH_HI 5
`define ADCSC_CTRL_CH_LO 3
`define ADCSC_CTRL_GO 2
`define ADCSC_CTRL_ON 0

// ----------------------------------------
// adc_port_config and irq fields
// ----------------------------------------
`define ADCSC_CFG_JUST 7
`define ADCSC_CFG_REFH 5
`define ADCSC_CFG_REFL 4
`define ADCSC_CFG_PINS_HI 3
`define ADCSC_CFG_PINS_LO 0
`define ADCSC_IRQ_FLAG 0
`define ADCSC_IRQ_EN 1
`define ADCSC_IRQ_GIE 2

// ----------------------------------------
// clock select codes and states
// ----------------------------------------
`define ADCSC_CLK_DIV2 2'h0
`define ADCSC_CLK_DIV8 2'h1
`define ADCSC_CLK_DIV32 2'h2
`define ADCSC_CLK_RC 2'h3
`define ADCSC_ST_ACQ 2'h0
`define ADCSC_ST_CONV 2'h1
`define ADCSC_ST_GAP 2'h2

`define ADCSC_RES_MSB 10'h200
`define ADCSC_HIGH_REF_CH 3
`define ADCSC_LOW_REF_CH 2

`endif

// [src/adcsc_sync2.v]
`timescale 1ns/10ps
`include "adcsc_consts.vh"

module adcsc_sync2 (
    input wire clk,
    input wire sys_rst,
    input wire asyncIn,
    output reg syncOut
);
    reg stage1;

    always @(posedge clk) begin
        if (sys_rst) begin
            stage1 <= 1'b0;
            syncOut <= 1'b0;
        end else begin
            stage1 <= asyncIn;
            syncOut <= stage1;
        end
    end
endmodule

// [src/adcsc_tad_gen.v]
`timescale 1ns/10ps
`include "adcsc_consts.vh"

module adcsc_tad_gen #(
    parameter OSC_DIV = `ADCSC_OSC_DIV,
    parameter RC_CYCLES = `ADCSC_RC_TAD_CYCLES
) (
    input wire clk,
    input wire sys_rst,
    input wire run,
    input wire [1:0] clkSel,
    output reg tick
);
    localparam integer FULL2 = `ADCSC_DIV_2 * OSC_DIV;
    localparam integer FULL8 = `ADCSC_DIV_8 * OSC_DIV;
    localparam integer FULL32 = `ADCSC_DIV_32 * OSC_DIV;
    localparam integer FULLRC = RC_CYCLES;
    // lengths beyond the counter width are cut on purpose
    localparam [`ADCSC_TAD_CNT_W-1:0] LEN2 = FULL2[`ADCSC_TAD_CNT_W-1:0];
    localparam [`ADCSC_TAD_CNT_W-1:0] LEN8 = FULL8[`ADCSC_TAD_CNT_W-1:0];
    localparam [`ADCSC_TAD_CNT_W-1:0] LEN32 = FULL32[`ADCSC_TAD_CNT_W-1:0];
    localparam [`ADCSC_TAD_CNT_W-1:0] LENRC = FULLRC[`ADCSC_TAD_CNT_W-1:0];
    localparam [`ADCSC_TAD_CNT_W-1:0] ONE = {{(`ADCSC_TAD_CNT_W-1){1'b0}}, 1'b1};

    reg [`ADCSC_TAD_CNT_W-1:0] count;
    reg [`ADCSC_TAD_CNT_W-1:0] period;

    // ----------------------------------------
    // period select
    // ----------------------------------------
    always @* begin
        case (clkSel)
            // RULE_05 oscillator dividers
            `ADCSC_CLK_DIV2: period = LEN2;
            `ADCSC_CLK_DIV8: period = LEN8;
            `ADCSC_CLK_DIV32: period = LEN32;
            // RULE_18 internal rc period
            default: period = LENRC;
        endcase
    end

    // ----------------------------------------
    // counter
    // ----------------------------------------
    // held in reset when idle, so the first segment is always a full tad
    always @(posedge clk) begin
        if (sys_rst || !run) begin
            count <= ONE;
            tick <= 1'b0;
        end else if (count >= period) begin
            count <= ONE;
            tick <= 1'b1;
        end else begin
            count <= count + ONE;
            tick <= 1'b0;
        end
    end
endmodule

// [src/adcsc_top.v]
// Functional notes
// RULE_01 - sar converts held input level into 10-bit code
// RULE_02 - five inputs on small variant, eight on large variant
// RULE_03 - software picks high and low references from rails or pins
// RULE_04 - conversion survives sleep only when clocked by internal rc
// RULE_05 - clock select bits 7:6: 00 div2, 01 div8, 10 div32
// RULE_06 - channel select bits 5:3 picks channel 0 to 7
// RULE_07 - port config sets pins analog or digital, one may be reference
// RULE_08 - software configures everything and powers module before start
// RULE_09 - software makes analog channel pins inputs before acquiring
// RULE_10 - software waits acquisition time after channel change
// RULE_11 - writing one to go starts conversion when module powered
// RULE_12 - completion loads 10-bit result into high/low result pair
// RULE_13 - completion clears go bit 2 in hardware
// RULE_14 - completion sets sticky done flag until software clears it
// RULE_15 - software clears flag, then sets irq enable and global enable
// RULE_16 - software polls go or waits for irq, then reads results
// RULE_17 - two tad wait after conversion before next acquisition
// RULE_18 - clock select 11 picks internal rc oscillator
// RULE_19 - full conversion takes at least twelve tad
// RULE_20 - clearing go mid conversion aborts, result unchanged
// RULE_21 - justify bit places result left or right, zero fill
// RULE_22 - go write ignored while module power bit clear
//
// The APB register port was decided locally.
`timescale 1ns/10ps
`include "adcsc_consts.vh"

module adcsc_top #(
    parameter NUM_CHANNELS = 8,
    parameter OSC_DIV = `ADCSC_OSC_DIV,
    parameter RC_CYCLES = `ADCSC_RC_TAD_CYCLES
) (
    input wire clk,
    input wire sys_rst,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    input wire compAbove,
    input wire sleepMode,
    output reg [9:0] dacCode,
    output reg sampleHold,
    output reg [2:0] channelSel,
    output reg [7:0] analogPinEnable,
    output reg highRefFromPin,
    output reg lowRefFromPin,
    output reg converterPowered,
    output reg rcOscEnable,
    output reg convDoneFlag,
    output reg irqRequest
);
    reg [1:0] clkSel;
    reg goBit;
    reg justifyLeft;
    reg [3:0] pinCfg;
    reg [7:0] resultHigh;
    reg [7:0] resultLow;
    reg irqEnable;
    reg globalEnable;
    reg [1:0] state;
    reg [3:0] step;
    reg [9:0] bitMask;
    reg [3:0] gapCount;
    reg [7:0] next_pinEnable;
    reg [7:0] readByte;
    reg [7:0] next_resHigh;
    reg [7:0] next_resLow;
    wire compSync;
    wire sleepSync;
    wire tadTick;
    wire [`ADCSC_IDX_W-1:0] regIdx;
    wire aligned;
    wire accessCycle;
    wire wrCycle;
    wire wrCtrl;
    wire wrCfg;
    wire wrResH;
    wire wrResL;
    wire wrIrq;
    wire sleepBad;
    wire abortConv;
    wire convDone;
    integer i;

    // ----------------------------------------
    // pin synchronisers and tad timebase
    // ----------------------------------------
    adcsc_sync2 uCompSync (
        .clk(clk),
        .sys_rst(sys_rst),
        .asyncIn(compAbove),
        .syncOut(compSync)
    );

    adcsc_sync2 uSleepSync (
        .clk(clk),
        .sys_rst(sys_rst),
        .asyncIn(sleepMode),
        .syncOut(sleepSync)
    );

    adcsc_tad_gen #(
        .OSC_DIV(OSC_DIV),
        .RC_CYCLES(RC_CYCLES)
    ) uTadGen (
        .clk(clk),
        .sys_rst(sys_rst),
        .run(state != `ADCSC_ST_ACQ),
        .clkSel(clkSel),
        .tick(tadTick)
    );

    // ----------------------------------------
    // apb decode
    // ----------------------------------------
    assign regIdx = paddr[11:2];
    assign aligned = (paddr[1:0] == 2'h0);
    assign accessCycle = psel & penable & pready;
    assign wrCycle = accessCycle & pwrite & aligned;
    assign wrCtrl = wrCycle & (regIdx == `ADCSC_IDX_CTRL);
    assign wrCfg = wrCycle & (regIdx == `ADCSC_IDX_CFG);
    assign wrResH = wrCycle & (regIdx == `ADCSC_IDX_RESH);
    assign wrResL = wrCycle & (regIdx == `ADCSC_IDX_RESL);
    assign wrIrq = wrCycle & (regIdx == `ADCSC_IDX_IRQ);

    always @* begin
        readByte = 8'h00;
        case (regIdx)
            `ADCSC_IDX_CTRL: begin
                readByte[`ADCSC_CTRL_CLK_HI:`ADCSC_CTRL_CLK_LO] = clkSel;
                readByte[`ADCSC_CTRL_CH_HI:`ADCSC_CTRL_CH_LO] = channelSel;
                readByte[`ADCSC_CTRL_GO] = goBit;
                readByte[`ADCSC_CTRL_ON] = converterPowered;
            end
            `ADCSC_IDX_CFG: begin
                readByte[`ADCSC_CFG_JUST] = justifyLeft;
                readByte[`ADCSC_CFG_REFH] = highRefFromPin;
                readByte[`ADCSC_CFG_REFL] = lowRefFromPin;
                readByte[`ADCSC_CFG_PINS_HI:`ADCSC_CFG_PINS_LO] = pinCfg;
            end
            `ADCSC_IDX_RESH: readByte = resultHigh;
            `ADCSC_IDX_RESL: readByte = resultLow;
            `ADCSC_IDX_IRQ: begin
                readByte[`ADCSC_IRQ_FLAG] = convDoneFlag;
                readByte[`ADCSC_IRQ_EN] = irqEnable;
                readByte[`ADCSC_IRQ_GIE] = globalEnable;
            end
            default: readByte = 8'h00;
        endcase
    end

    // one wait state: pready rises in the second access cycle
    always @(posedge clk) begin
        if (sys_rst) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h00000000;
        end else if (psel && penable && !pready) begin
            pready <= 1'b1;
            prdata <= {24'h000000, readByte};
            pslverr <= !aligned || !(regIdx == `ADCSC_IDX_CTRL ||
                regIdx == `ADCSC_IDX_CFG || regIdx == `ADCSC_IDX_RESH ||
                regIdx == `ADCSC_IDX_RESL || regIdx == `ADCSC_IDX_IRQ);
        end else begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h00000000;
        end
    end

    // ----------------------------------------
    // conversion events
    // ----------------------------------------
    // RULE_04 non-rc clock stops in sleep
    assign sleepBad = sleepSync && (clkSel != `ADCSC_CLK_RC);
    // RULE_20 abort on go clear
    assign abortConv = (state == `ADCSC_ST_CONV) &&
        (!goBit || !converterPowered || sleepBad);
    // RULE_19 thirteen full tads, done on the tick at step 12
    assign convDone = (state == `ADCSC_ST_CONV) && !abortConv && tadTick &&
        (step == `ADCSC_STEP_LOAD);

    // ----------------------------------------
    // control registers
    // ----------------------------------------
    always @(posedge clk) begin
        if (sys_rst) begin
            clkSel <= 2'h0;
            channelSel <= 3'h0;
            converterPowered <= 1'b0;
            goBit <= 1'b0;
            justifyLeft <= 1'b0;
            highRefFromPin <= 1'b0;
            lowRefFromPin <= 1'b0;
            pinCfg <= 4'h0;
        end else begin
            if (wrCtrl) begin
                // RULE_05 clock select
                clkSel <= pwdata[`ADCSC_CTRL_CLK_HI:`ADCSC_CTRL_CLK_LO];
                // RULE_06 channel select
                channelSel <= pwdata[`ADCSC_CTRL_CH_HI:`ADCSC_CTRL_CH_LO];
                converterPowered <= pwdata[`ADCSC_CTRL_ON];
            end
            // RULE_11 software start wins
            if (wrCtrl && pwdata[`ADCSC_CTRL_GO] && converterPowered) begin
                goBit <= 1'b1;
            // RULE_13 hardware clear
            end else if (convDone || abortConv) begin
                goBit <= 1'b0;
            end else if (wrCtrl) begin
                // RULE_22 start ignored unpowered
                goBit <= 1'b0;
            end
            if (wrCfg) begin
                // RULE_21 justify select
                justifyLeft <= pwdata[`ADCSC_CFG_JUST];
                // RULE_03 reference select
                highRefFromPin <= pwdata[`ADCSC_CFG_REFH];
                lowRefFromPin <= pwdata[`ADCSC_CFG_REFL];
                pinCfg <= pwdata[`ADCSC_CFG_PINS_HI:`ADCSC_CFG_PINS_LO];
            end
        end
    end

    // ----------------------------------------
    // pin configuration decode
    // ----------------------------------------
    always @* begin
        next_pinEnable = 8'h00;
        for (i = 0; i < 8; i = i + 1) begin
            // RULE_02 channel count
            // RULE_07 analog or digital
            next_pinEnable[i] = (i < NUM_CHANNELS) && (i + pinCfg < 8) &&
                !(i == `ADCSC_HIGH_REF_CH && highRefFromPin) &&
                !(i == `ADCSC_LOW_REF_CH && lowRefFromPin);
        end
    end

    always @(posedge clk) begin
        if (sys_rst) begin
            analogPinEnable <= 8'h00;
            rcOscEnable <= 1'b0;
        end else begin
            analogPinEnable <= next_pinEnable;
            // RULE_18 rc oscillator runs
            rcOscEnable <= converterPowered && (clkSel == `ADCSC_CLK_RC);
        end
    end

    // ----------------------------------------
    // successive approximation sequencer
    // ----------------------------------------
    // comparator is sampled through two flops; it must settle within tad - 2
    always @(posedge clk) begin
        if (sys_rst) begin
            state <= `ADCSC_ST_ACQ;
            step <= 4'h0;
            bitMask <= 10'h000;
            dacCode <= 10'h000;
            sampleHold <= 1'b0;
            gapCount <= 4'h0;
        end else begin
            case (state)
                `ADCSC_ST_ACQ: begin
                    sampleHold <= 1'b0;
                    // RULE_11 begin conversion
                    if (goBit && converterPowered && !sleepBad) begin
                        state <= `ADCSC_ST_CONV;
                        sampleHold <= 1'b1;
                        step <= 4'h0;
                        bitMask <= 10'h000;
                    end
                end
                `ADCSC_ST_CONV: begin
                    if (abortConv || convDone) begin
                        state <= `ADCSC_ST_GAP;
                        gapCount <= 4'h0;
                    end else if (tadTick) begin
                        step <= step + 4'h1;
                        if (step == `ADCSC_STEP_TRIAL) begin
                            bitMask <= `ADCSC_RES_MSB;
                            dacCode <= `ADCSC_RES_MSB;
                        end else if (bitMask != 10'h000) begin
                            // RULE_01 keep or drop trial bit
                            dacCode <= (compSync ? dacCode : (dacCode & ~bitMask)) |
                                (bitMask >> 1);
                            bitMask <= bitMask >> 1;
                        end
                    end
                end
                `ADCSC_ST_GAP: begin
                    // RULE_17 hold disconnected two tads
                    if (tadTick) begin
                        gapCount <= gapCount + 4'h1;
                        if (gapCount + 4'h1 >= `ADCSC_GAP_TADS) begin
                            state <= `ADCSC_ST_ACQ;
                            sampleHold <= 1'b0;
                        end
                    end
                end
                default: state <= `ADCSC_ST_ACQ;
            endcase
        end
    end

    // ----------------------------------------
    // result pair and done flag
    // ----------------------------------------
    always @* begin
        if (justifyLeft) begin
            next_resHigh = dacCode[9:2];
            next_resLow = {dacCode[1:0], 6'h00};
        end else begin
            next_resHigh = {6'h00, dacCode[9:8]};
            next_resLow = dacCode[7:0];
        end
    end

    always @(posedge clk) begin
        if (sys_rst) begin
            resultHigh <= 8'h00;
            resultLow <= 8'h00;
            convDoneFlag <= 1'b0;
            irqEnable <= 1'b0;
            globalEnable <= 1'b0;
            irqRequest <= 1'b0;
        end else begin
            // RULE_12 load result pair
            if (convDone) begin
                resultHigh <= next_resHigh;
                resultLow <= next_resLow;
            end else begin
                if (wrResH) begin
                    resultHigh <= pwdata[7:0];
                end
                if (wrResL) begin
                    resultLow <= pwdata[7:0];
                end
            end
            // RULE_14 set wins clear
            if (convDone) begin
                convDoneFlag <= 1'b1;
            end else if (wrIrq) begin
                convDoneFlag <= pwdata[`ADCSC_IRQ_FLAG];
            end
            if (wrIrq) begin
                irqEnable <= pwdata[`ADCSC_IRQ_EN];
                globalEnable <= pwdata[`ADCSC_IRQ_GIE];
            end
            irqRequest <= convDoneFlag && irqEnable && globalEnable;
        end
    end
endmodule

// [tb/adcsc_top_asserts.sv]
`timescale 1ns/10ps
module adcsc_top_asserts (
    input wire clk,
    input wire sys_rst,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] prdata,
    input wire pready,
    input wire pslverr,
    input wire sampleHold,
    input wire converterPowered,
    input wire rcOscEnable,
    input wire convDoneFlag,
    input wire irqRequest
);
// ----------------------------------------
// helpers
// ----------------------------------------
localparam int MIN_TAD = 10;
wire done = psel && penable && pready;
wire irqWr = done && pwrite && paddr == 12'h080;
wire mapped = paddr == 12'h078 || paddr == 12'h07C || paddr == 12'h080 ||
    paddr == 12'h278 || paddr == 12'h27C;
reg [15:0] holdCnt;
always @(posedge clk) begin
    if (sys_rst || !sampleHold) holdCnt <= 16'h0;
    else if (holdCnt != 16'hFFFF) holdCnt <= holdCnt + 16'h1;
end
default clocking cb @(posedge clk); endclocking
default disable iff (sys_rst);
// ----------------------------------------
// assertions
// ----------------------------------------
property p_one_wait; psel && penable && !pready |=> pready; endproperty
a_one_wait: assert property (p_one_wait) else $error("pready late");
property p_ready_pulse; pready |=> !pready; endproperty
a_ready_pulse: assert property (p_ready_pulse) else $error("pready long");
property p_rdata_idle; !pready |-> prdata == 32'h0; endproperty
a_rdata_idle: assert property (p_rdata_idle) else $error("prdata idle");
property p_slverr; done |-> pslverr == !mapped && prdata[31:8] == 24'h0; endproperty
a_slverr: assert property (p_slverr) else $error("bad response");
property p_flag_sticky; convDoneFlag && !irqWr |=> convDoneFlag; endproperty
a_flag_sticky: assert property (p_flag_sticky) else $error("flag lost");
property p_irq_late; irqRequest |-> $past(convDoneFlag); endproperty
a_irq_late: assert property (p_irq_late) else $error("irq early");
property p_rc_src; rcOscEnable |-> converterPowered; endproperty
a_rc_src: assert property (p_rc_src) else $error("rc unpowered");
property p_no_start_off; $rose(sampleHold) |-> converterPowered; endproperty
a_no_start_off: assert property (p_no_start_off) else $error("start unpowered");
property p_gap; $rose(convDoneFlag) |-> sampleHold [*8]; endproperty
a_gap: assert property (p_gap) else $error("gap short");
property p_min_conv; $rose(convDoneFlag) |-> holdCnt >= 12 * MIN_TAD; endproperty
a_min_conv: assert property (p_min_conv) else $error("conversion short");
endmodule

bind adcsc_top adcsc_top_asserts chk (.clk(clk), .sys_rst(sys_rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .sampleHold(sampleHold), .converterPowered(converterPowered),
    .rcOscEnable(rcOscEnable), .convDoneFlag(convDoneFlag), .irqRequest(irqRequest));

// [tb/adcsc_analog_model.sv]
`timescale 1ns/10ps
module adcsc_analog_model (
    input wire [79:0] chanLevels,
    input wire [2:0] channelSel,
    input wire [9:0] dacCode,
    output reg compAbove
);
// ----------------------------------------
// ideal comparator
// ----------------------------------------
// selected input level
always @* begin
    compAbove = chanLevels[channelSel * 10 +: 10] >= dacCode;
end
endmodule

// [tb/adc_sar_control_test.sv]
`timescale 1ns/10ps
`define CHK(g, e) begin checkCount = checkCount + 1; if ((g) !== (e)) begin \
    miscompares = miscompares + 1; $display("[ERR] %0t got %0h exp %0h", $time, g, e); end end
module adc_sar_control_test;
localparam [11:0] A_RH = 12'h078, A_CT = 12'h07C, A_IR = 12'h080;
localparam [11:0] A_RL = 12'h278, A_CF = 12'h27C;
reg clk = 1'b0;
reg sysRst = 1'b1;
reg psel = 1'b0, penable = 1'b0, pwrite = 1'b0, sleepMode = 1'b0;
reg [11:0] paddr = 12'h0;
reg [31:0] pwdata = 32'h0;
wire [31:0] prdata;
wire pready, pslverr, compAbove, sampleHold, highRef, lowRef, powered, rcOn, flag, irq;
wire [9:0] dacCode;
wire [2:0] channelSel;
wire [7:0] pinEn;
wire [79:0] levels = {10'h3FF, 10'h2AA, 10'h2AA, 10'h001, 10'h155, 10'h200, 10'h1FF, 10'h000};
integer miscompares = 0, checkCount = 0, cycles = 0;
reg [31:0] rd;
reg err;
reg [7:0] lastH, lastL;
adcsc_top #(.NUM_CHANNELS(8), .OSC_DIV(5), .RC_CYCLES(10)) dut (.clk(clk), .sys_rst(sysRst),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .compAbove(compAbove),
    .sleepMode(sleepMode), .dacCode(dacCode), .sampleHold(sampleHold),
    .channelSel(channelSel), .analogPinEnable(pinEn), .highRefFromPin(highRef),
    .lowRefFromPin(lowRef), .converterPowered(powered), .rcOscEnable(rcOn),
    .convDoneFlag(flag), .irqRequest(irq));
adcsc_analog_model ana (.chanLevels(levels), .channelSel(channelSel), .dacCode(dacCode),
    .compAbove(compAbove));
always #5 clk = ~clk;
always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
        miscompares = miscompares + 1;
        results;
    end
end
// ----------------------------------------
// bus tasks
// ----------------------------------------
task apb(input reg wr, input reg [11:0] a, input reg [7:0] wd);
    begin
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= {24'h0, wd};
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        // ends when pready rises; no limit here, so only the bench timeout ends a hang
        while (pready !== 1'b1) begin
            @(posedge clk);
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    end
endtask
task rdchk(input reg [11:0] a, input reg [7:0] e);
    begin
        apb(1'b0, a, 8'h0);
        `CHK(rd, ({24'h0, e}))
    end
endtask
task waitDone;
    integer n;
    begin
        n = 0;
        rd = 32'h4;
        while (rd[2] !== 1'b0 && n < 2000) begin
            apb(1'b0, A_CT, 8'h0);
            n = n + 1;
        end
    end
endtask
// ----------------------------------------
// scenarios
// ----------------------------------------
task t_regs;
    begin
        rdchk(A_CT, 8'h00);
        rdchk(A_CF, 8'h00);
        rdchk(A_IR, 8'h00);
        apb(1'b0, 12'h100, 8'h0);
        `CHK(err, 1'b1)
        apb(1'b1, 12'h07D, 8'hFF);
        `CHK(err, 1'b1)
        rdchk(A_CT, 8'h00);
        apb(1'b1, A_CF, 8'h32);
        // pin enables settle one edge after the config register
        @(posedge clk);
        `CHK(pinEn, 8'h33)
        `CHK(({highRef, lowRef}), 2'h3)
        rdchk(A_CF, 8'h32);
    end
endtask
task t_nopower;
    begin
        apb(1'b1, A_CT, 8'h04);
        rdchk(A_CT, 8'h00);
        apb(1'b1, A_CT, 8'h05);
        rdchk(A_CT, 8'h01);
        `CHK(sampleHold, 1'b0)
        apb(1'b1, A_CT, 8'h00);
    end
endtask
task t_conv(input reg [1:0] sel, input reg [2:0] ch, input reg left);
    reg [9:0] r;
    begin
        r = levels[ch * 10 +: 10];
        sleepMode <= (sel == 2'h3);
        apb(1'b1, A_CF, {left, 7'h0});
        apb(1'b1, A_IR, 8'h06);
        apb(1'b1, A_CT, {sel, ch, 3'h1});
        `CHK(channelSel, ch)
        `CHK(powered, 1'b1)
        `CHK(flag, 1'b0)
        repeat (20) @(posedge clk);
        `CHK(rcOn, sel == 2'h3)
        apb(1'b1, A_CT, {sel, ch, 3'h5});
        waitDone;
        `CHK(rd[7:0], ({sel, ch, 3'h1}))
        lastH = left ? r[9:2] : {6'h0, r[9:8]};
        lastL = left ? {r[1:0], 6'h0} : r[7:0];
        rdchk(A_RH, lastH);
        rdchk(A_RL, lastL);
        rdchk(A_IR, 8'h07);
        `CHK(irq, 1'b1)
        apb(1'b1, A_IR, 8'h00);
        `CHK(flag, 1'b0)
        sleepMode <= 1'b0;
    end
endtask
task t_abort(input reg bySleep);
    begin
        apb(1'b1, A_CT, 8'h09);
        repeat (20) @(posedge clk);
        apb(1'b1, A_CT, 8'h0D);
        repeat (40) @(posedge clk);
        if (bySleep) sleepMode <= 1'b1;
        else apb(1'b1, A_CT, 8'h09);
        repeat (300) @(posedge clk);
        sleepMode <= 1'b0;
        `CHK(flag, 1'b0)
        rdchk(A_RH, lastH);
        rdchk(A_RL, lastL);
        apb(1'b1, A_CT, 8'h00);
        repeat (40) @(posedge clk);
    end
endtask
task results;
    begin
        $display("checks %0d mismatches %0d", checkCount, miscompares);
        if (miscompares == 0 && checkCount > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    end
endtask
initial begin
    repeat (6) @(posedge clk);
    sysRst <= 1'b0;
    @(posedge clk);
    t_regs;
    t_nopower;
    t_conv(2'h0, 3'h0, 1'b0);
    t_conv(2'h1, 3'h5, 1'b1);
    t_conv(2'h2, 3'h7, 1'b0);
    t_conv(2'h3, 3'h3, 1'b1);
    t_abort(1'b0);
    t_abort(1'b1);
    results;
end
endmodule
